// File: asfe_pkg.sv
package asfe_pkg;

    localparam logic [7:0] START_DELIM = 8'h7e;
    localparam logic [7:0] TYPE_REG_STATUS = 8'ha4;
    localparam logic [7:0] TYPE_ROUTE_REQ = 8'ha3;
    localparam logic [7:0] TYPE_UNLOCK_RSP = 8'hac;
    localparam logic [7:0] CHECKSUM_BASE = 8'hff;

    localparam logic [7:0] REG_OK = 8'h00;
    localparam logic [7:0] REG_KEY_TOO_LONG = 8'h01;
    localparam logic [7:0] REG_TRANSIENT_FULL = 8'h18;
    localparam logic [7:0] REG_ADDR_NOT_FOUND = 8'hb1;
    localparam logic [7:0] REG_KEY_INVALID = 8'hb2;
    localparam logic [7:0] REG_ADDR_INVALID = 8'hb3;
    localparam logic [7:0] REG_TABLE_FULL = 8'hb4;
    localparam logic [7:0] REG_SEC_DATA_BAD = 8'hbd;

    localparam logic [15:0] LEN_REG_STATUS = 16'h0003;
    localparam logic [15:0] LEN_ROUTE_REQ = 16'h000c;
    localparam logic [7:0] OFS_BODY = 8'h03;
    localparam logic [7:0] OFS_ROUTE_NWK = 8'h0c;
    localparam logic [7:0] OFS_ROUTE_OPT = 8'h0e;
    localparam logic [7:0] ROUTE_OPT_VALUE = 8'h00;

    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HEAD = 2'b01,
        ST_BODY = 2'b10,
        ST_SUM = 2'b11
    } asfe_state_type;

    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_REG = 2'b01,
        SRC_ROUTE = 2'b10,
        SRC_UNLOCK = 2'b11
    } asfe_src_type;

endpackage

// File: asfe_fifo.sv
module asfe_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = asfe_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Fill side.
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side.
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic do_wr;
    logic do_rd;

    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_ff @(posedge ref_clk)
    begin
        if (do_wr)
        begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (do_rd)
            begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (do_wr && !do_rd)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (do_rd && !do_wr)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule

// File: asfe_emitter.sv
module asfe_emitter #(
    parameter int UNLOCK_MAX = 64
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Registration result event.
    input wire logic reg_valid,
    output logic reg_ready,
    input wire logic [7:0] reg_frame_id,
    input wire logic [7:0] reg_code,
    input wire logic reg_key_reserved,
    input wire logic reg_crc_fail,
    // Route request event.
    input wire logic route_valid,
    output logic route_ready,
    input wire logic [63:0] route_addr64,
    input wire logic [15:0] route_addr16,
    // Unlock response body stream, first byte after the type byte.
    input wire logic unlock_valid,
    output logic unlock_ready,
    input wire logic [7:0] unlock_data,
    input wire logic unlock_last,
    // Serial byte stream to the host.
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // Status.
    output logic busy
);
    localparam int UAW = $clog2(UNLOCK_MAX);

    asfe_pkg::asfe_state_type state_r;
    asfe_pkg::asfe_src_type src_r;
    logic [7:0] idx_r;
    logic [15:0] len_r;
    logic [7:0] sum_r;
    logic [7:0] fid_r;
    logic [7:0] code_r;
    logic [63:0] a64_r;
    logic [15:0] a16_r;
    logic [7:0] ubuf_r [UNLOCK_MAX];
    logic [UAW:0] ucnt_r;
    logic ucollect_r;
    logic [7:0] byte_nxt;
    logic [7:0] reg_code_nxt;
    logic f_valid;
    logic f_ready;
    logic push;
    logic start_reg;
    logic start_route;
    logic start_unlock;
    logic body_end;

    // Unlock body bytes are gathered before the frame so the length is known.
    assign unlock_ready = ucollect_r && (ucnt_r != (UAW+1)'(UNLOCK_MAX));
    assign start_reg = (state_r == asfe_pkg::ST_IDLE) && reg_valid;
    assign start_route = (state_r == asfe_pkg::ST_IDLE) && !reg_valid && route_valid;
    assign start_unlock = (state_r == asfe_pkg::ST_IDLE) && !reg_valid && !route_valid
        && !ucollect_r && ucnt_r != '0;
    assign reg_ready = start_reg;
    assign route_ready = start_route;
    assign push = f_valid && f_ready;
    assign body_end = (idx_r == len_r[7:0] + asfe_pkg::OFS_BODY - 8'h01);

    // Reserved keys and failed install codes override the reported result.
    always_comb
    begin
        if (reg_key_reserved)
        begin
            reg_code_nxt = asfe_pkg::REG_KEY_INVALID;
        end
        else if (reg_crc_fail)
        begin
            reg_code_nxt = asfe_pkg::REG_SEC_DATA_BAD;
        end
        else
        begin
            unique case (reg_code)
                asfe_pkg::REG_OK, asfe_pkg::REG_KEY_TOO_LONG,
                asfe_pkg::REG_TRANSIENT_FULL: reg_code_nxt = reg_code;
                asfe_pkg::REG_ADDR_NOT_FOUND, asfe_pkg::REG_ADDR_INVALID,
                asfe_pkg::REG_TABLE_FULL: reg_code_nxt = reg_code;
                asfe_pkg::REG_KEY_INVALID: reg_code_nxt = reg_code;
                default: reg_code_nxt = asfe_pkg::REG_SEC_DATA_BAD;
            endcase
        end
    end

    // Byte that belongs at the current offset.
    always_comb
    begin
        byte_nxt = 8'h00;
        unique case (state_r)
            asfe_pkg::ST_HEAD:
            begin
                if (idx_r == 8'h00)
                begin
                    byte_nxt = asfe_pkg::START_DELIM;
                end
                else if (idx_r == 8'h01)
                begin
                    byte_nxt = len_r[15:8];
                end
                else
                begin
                    byte_nxt = len_r[7:0];
                end
            end
            asfe_pkg::ST_BODY:
            begin
                if (idx_r == asfe_pkg::OFS_BODY)
                begin
                    unique case (src_r)
                        asfe_pkg::SRC_REG: byte_nxt = asfe_pkg::TYPE_REG_STATUS;
                        asfe_pkg::SRC_ROUTE: byte_nxt = asfe_pkg::TYPE_ROUTE_REQ;
                        default: byte_nxt = asfe_pkg::TYPE_UNLOCK_RSP;
                    endcase
                end
                else if (src_r == asfe_pkg::SRC_REG)
                begin
                    byte_nxt = (idx_r == 8'h04) ? fid_r : code_r;
                end
                else if (src_r == asfe_pkg::SRC_ROUTE)
                begin
                    if (idx_r < asfe_pkg::OFS_ROUTE_NWK)
                    begin
                        byte_nxt = a64_r[8 * (4'hb - idx_r[3:0]) +: 8];
                    end
                    else if (idx_r < asfe_pkg::OFS_ROUTE_OPT)
                    begin
                        byte_nxt = idx_r[0] ? a16_r[7:0] : a16_r[15:8];
                    end
                    else
                    begin
                        byte_nxt = asfe_pkg::ROUTE_OPT_VALUE;
                    end
                end
                else
                begin
                    byte_nxt = ubuf_r[UAW'(idx_r - 8'h04)];
                end
            end
            asfe_pkg::ST_SUM: byte_nxt = asfe_pkg::CHECKSUM_BASE - sum_r;
            default: byte_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (unlock_valid && unlock_ready)
        begin
            ubuf_r[ucnt_r[UAW-1:0]] <= unlock_data;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ucnt_r <= '0;
            ucollect_r <= 1'b1;
        end
        else if (unlock_valid && unlock_ready)
        begin
            ucnt_r <= ucnt_r + 1'b1;
            ucollect_r <= !unlock_last;
        end
        else if (src_r == asfe_pkg::SRC_UNLOCK && state_r == asfe_pkg::ST_SUM && push)
        begin
            ucnt_r <= '0;
            ucollect_r <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (start_reg)
        begin
            fid_r <= reg_frame_id;
            code_r <= reg_code_nxt;
        end
        if (start_route)
        begin
            a64_r <= route_addr64;
            a16_r <= route_addr16;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_r <= asfe_pkg::ST_IDLE;
            src_r <= asfe_pkg::SRC_NONE;
            idx_r <= 8'h00;
            len_r <= 16'h0000;
            sum_r <= 8'h00;
        end
        else
        begin
            unique case (state_r)
                asfe_pkg::ST_IDLE:
                begin
                    idx_r <= 8'h00;
                    sum_r <= 8'h00;
                    if (start_reg && reg_frame_id != 8'h00)
                    begin
                        state_r <= asfe_pkg::ST_HEAD;
                        src_r <= asfe_pkg::SRC_REG;
                        len_r <= asfe_pkg::LEN_REG_STATUS;
                    end
                    else if (start_route)
                    begin
                        state_r <= asfe_pkg::ST_HEAD;
                        src_r <= asfe_pkg::SRC_ROUTE;
                        len_r <= asfe_pkg::LEN_ROUTE_REQ;
                    end
                    else if (start_unlock)
                    begin
                        state_r <= asfe_pkg::ST_HEAD;
                        src_r <= asfe_pkg::SRC_UNLOCK;
                        len_r <= 16'(ucnt_r) + 16'h0001;
                    end
                end
                asfe_pkg::ST_HEAD:
                begin
                    if (push)
                    begin
                        idx_r <= idx_r + 8'h01;
                        if (idx_r == 8'h02)
                        begin
                            state_r <= asfe_pkg::ST_BODY;
                        end
                    end
                end
                asfe_pkg::ST_BODY:
                begin
                    if (push)
                    begin
                        idx_r <= idx_r + 8'h01;
                        sum_r <= sum_r + byte_nxt;
                        if (body_end)
                        begin
                            state_r <= asfe_pkg::ST_SUM;
                        end
                    end
                end
                asfe_pkg::ST_SUM:
                begin
                    if (push)
                    begin
                        state_r <= asfe_pkg::ST_IDLE;
                        src_r <= asfe_pkg::SRC_NONE;
                    end
                end
            endcase
        end
    end

    assign f_valid = (state_r != asfe_pkg::ST_IDLE);

    // Output bytes pass the FIFO so the host side can stall the framer.
    asfe_fifo #(
        .WIDTH(8),
        .DEPTH(asfe_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_data(byte_nxt),
        .in_valid(f_valid),
        .in_ready(f_ready),
        .out_data(tx_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready)
    );

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            busy <= 1'b0;
        end
        else
        begin
            busy <= (state_r != asfe_pkg::ST_IDLE) || tx_valid;
        end
    end

endmodule

// File: asfe_emitter_properties.sv
module asfe_emitter_properties (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Event handshakes.
    input wire logic reg_valid,
    input wire logic reg_ready,
    input wire logic [7:0] reg_frame_id,
    input wire logic route_valid,
    input wire logic route_ready,
    input wire logic unlock_valid,
    input wire logic unlock_ready,
    input wire logic unlock_last,
    // Byte stream and status.
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] idx_r;
    logic [15:0] len_r;
    logic [7:0] sum_r;
    logic [7:0] type_r;
    wire logic acc = tx_valid && tx_ready;
    wire logic at_sum = idx_r > 16'h0002 && idx_r == len_r + 16'h0003;
    // Position of the next byte within its frame.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            idx_r <= 16'h0000;
        else if (acc)
            idx_r <= at_sum ? 16'h0000 : idx_r + 16'h0001;
    end
    // Length, type and running sum of the frame on the wire.
    always_ff @(posedge ref_clk)
    begin
        if (acc && idx_r == 16'h0001)
            len_r[15:8] <= tx_data;
        if (acc && idx_r == 16'h0002)
            len_r[7:0] <= tx_data;
        if (acc && idx_r == 16'h0003)
            type_r <= tx_data;
        if (acc)
            sum_r <= idx_r < 16'h0003 ? 8'h00 : sum_r + tx_data;
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_delim;
        ##[1:3] (tx_valid && tx_data == asfe_pkg::START_DELIM);
    endsequence
    a_hold_valid: assert property (tx_valid && !tx_ready |=> tx_valid)
        else $error("stalled byte withdrawn");
    a_hold_data: assert property (tx_valid && !tx_ready |=> $stable(tx_data))
        else $error("stalled byte changed");
    a_reg_start: assert property (!busy && reg_valid && reg_ready && reg_frame_id != 8'h00
        |-> s_delim) else $error("no frame after registration");
    a_drop_zero: assert property (!busy && reg_valid && reg_ready && reg_frame_id == 8'h00
        |=> !tx_valid [*2]) else $error("frame sent for zero id");
    a_route_start: assert property (!busy && route_valid && route_ready |-> s_delim)
        else $error("no frame after route request");
    a_unlock_lock: assert property (unlock_valid && unlock_ready && unlock_last
        |=> !unlock_ready) else $error("unlock body taken past end");
    a_route_opt: assert property (tx_valid && idx_r == 16'h000e
        && type_r == asfe_pkg::TYPE_ROUTE_REQ |-> tx_data == asfe_pkg::ROUTE_OPT_VALUE)
        else $error("route options not zero");
    a_frame_sum: assert property (acc && at_sum
        |-> tx_data == asfe_pkg::CHECKSUM_BASE - sum_r) else $error("checksum wrong");
endmodule

bind asfe_emitter asfe_emitter_properties chk_u (.ref_clk, .rst, .reg_valid, .reg_ready,
    .reg_frame_id, .route_valid, .route_ready, .unlock_valid, .unlock_ready, .unlock_last,
    .tx_data, .tx_valid, .tx_ready, .busy);

// File: asfe_host_model.sv
module asfe_host_model (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Byte stream from the emitter.
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // Holds off the stream while high.
    input wire logic stall
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];
    int unicasts = 0;
    assign tx_ready = !stall;
    // Stands in for the unicast answer to a route request; nothing is sent, only counted here.
    task automatic answer_route();
        unicasts++;
    endtask
    // Bytes are kept only from a start byte on, so a broken stream resynchronises.
    always @(posedge ref_clk)
    begin
        if (rst)
            rx_q.delete();
        else if (tx_valid && tx_ready && (rx_q.size() > 0 || tx_data == asfe_pkg::START_DELIM))
            rx_q.push_back(tx_data);
    end
endmodule

// File: asfe_emitter_tb_top.sv
module asfe_emitter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] id;
        logic [7:0] code;
        logic kr;
        logic crc;
        logic [7:0] res;
    } asfe_row_type;
    localparam asfe_row_type ROWS[11] = '{'{8'h5d, 8'h00, 0, 0, 8'h00},
        '{8'h01, 8'h01, 0, 0, 8'h01}, '{8'h02, 8'h18, 0, 0, 8'h18}, '{8'h03, 8'hb1, 0, 0, 8'hb1},
        '{8'h04, 8'hb2, 0, 0, 8'hb2}, '{8'h05, 8'hb3, 0, 0, 8'hb3}, '{8'h06, 8'hb4, 0, 0, 8'hb4},
        '{8'h07, 8'hbd, 0, 0, 8'hbd}, '{8'h08, 8'h00, 1, 0, 8'hb2}, '{8'h09, 8'h00, 0, 1, 8'hbd},
        '{8'h0a, 8'h55, 0, 0, 8'hbd}};
    logic ref_clk = 1'b0, rst = 1'b1, stall = 1'b0, reg_valid = 1'b0, route_valid = 1'b0;
    logic reg_key_reserved = 1'b0, reg_crc_fail = 1'b0, unlock_valid = 1'b0, unlock_last = 1'b0;
    logic [7:0] reg_frame_id = 8'h00, reg_code = 8'h00, unlock_data = 8'h00;
    logic [63:0] route_addr64 = 64'h1122334455667788;
    logic [15:0] route_addr16 = 16'h9abc;
    logic reg_ready, route_ready, unlock_ready, tx_valid, tx_ready, busy;
    logic [7:0] tx_data;
    logic [7:0] body[$];
    int miscompares = 0, total_checks = 0;
    always #10 ref_clk = ~ref_clk;
    asfe_emitter dut_u (.ref_clk, .rst, .reg_valid, .reg_ready, .reg_frame_id, .reg_code,
        .reg_key_reserved, .reg_crc_fail, .route_valid, .route_ready, .route_addr64,
        .route_addr16, .unlock_valid, .unlock_ready, .unlock_data, .unlock_last, .tx_data,
        .tx_valid, .tx_ready, .busy);
    asfe_host_model host_u (.ref_clk, .rst, .tx_data, .tx_valid, .tx_ready, .stall);
    task automatic summarize();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic stuck();
        miscompares++;
        $display("mismatch at %0t: wait ran out", $time);
        summarize();
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: byte %h, want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: flag %b, want %b", $time, got, exp);
        end
    endtask
    // Waits until the chosen ready is sampled high at a falling edge, ending on the next rising edge.
    task automatic hs(input int k);
        int n;
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while ((k == 0 ? reg_ready : k == 1 ? route_ready : unlock_ready) !== 1'b1 && n < 200);
        if (n >= 200)
            stuck();
        @(posedge ref_clk);
    endtask
    task automatic route_body();
        for (int i = 7; i >= 0; i--)
            body.push_back(route_addr64[i*8 +: 8]);
        body.push_back(route_addr16[15:8]);
        body.push_back(route_addr16[7:0]);
        body.push_back(asfe_pkg::ROUTE_OPT_VALUE);
    endtask
    // Compares the next frame taken by the host with type t and the queued body.
    task automatic frame(input logic [7:0] t);
        logic [7:0] s;
        int n;
        s = 8'h00;
        n = 0;
        body.push_front(t);
        while (host_u.rx_q.size() < body.size() + 4 && n < 500)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 500)
            stuck();
        chk8(host_u.rx_q.pop_front(), asfe_pkg::START_DELIM);
        chk8(host_u.rx_q.pop_front(), 8'h00);
        chk8(host_u.rx_q.pop_front(), 8'(body.size()));
        foreach (body[i])
        begin
            chk8(host_u.rx_q.pop_front(), body[i]);
            s += body[i];
        end
        chk8(host_u.rx_q.pop_front(), asfe_pkg::CHECKSUM_BASE - s);
        body.delete();
        @(posedge ref_clk);
    endtask
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk1(tx_valid, 1'b0);
        chk1(unlock_ready, 1'b1);
        foreach (ROWS[i])
        begin
            @(posedge ref_clk);
            {reg_frame_id, reg_code, reg_key_reserved, reg_crc_fail} <= ROWS[i][25:8];
            reg_valid <= 1'b1;
            hs(0);
            reg_valid <= 1'b0;
            body = '{ROWS[i].id, ROWS[i].res};
            frame(asfe_pkg::TYPE_REG_STATUS);
        end
        reg_frame_id <= 8'h00;
        reg_valid <= 1'b1;
        route_valid <= 1'b1;
        hs(0);
        reg_valid <= 1'b0;
        hs(1);
        route_valid <= 1'b0;
        route_body();
        frame(asfe_pkg::TYPE_ROUTE_REQ);
        host_u.answer_route();
        stall <= 1'b1;
        reg_frame_id <= 8'h3c;
        reg_valid <= 1'b1;
        route_valid <= 1'b1;
        hs(0);
        reg_valid <= 1'b0;
        hs(1);
        route_valid <= 1'b0;
        @(negedge ref_clk);
        chk1(tx_valid, 1'b1);
        chk1(busy, 1'b1);
        @(posedge ref_clk);
        stall <= 1'b0;
        body = '{8'h3c, asfe_pkg::REG_SEC_DATA_BAD};
        frame(asfe_pkg::TYPE_REG_STATUS);
        route_body();
        frame(asfe_pkg::TYPE_ROUTE_REQ);
        host_u.answer_route();
        for (int i = 0; i < 5; i++)
        begin
            unlock_data <= 8'h40 + 8'(i);
            unlock_last <= (i == 4);
            unlock_valid <= 1'b1;
            hs(2);
            body.push_back(8'h40 + 8'(i));
        end
        unlock_valid <= 1'b0;
        unlock_last <= 1'b0;
        @(negedge ref_clk);
        chk1(unlock_ready, 1'b0);
        frame(asfe_pkg::TYPE_UNLOCK_RSP);
        chk8(8'(host_u.unicasts), 8'h02);
        stall <= 1'b1;
        reg_frame_id <= 8'h77;
        reg_valid <= 1'b1;
        hs(0);
        reg_valid <= 1'b0;
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        stall <= 1'b0;
        @(negedge ref_clk);
        chk1(tx_valid, 1'b0);
        chk1(busy, 1'b0);
        summarize();
    end
endmodule
